// file: remote_arb_asserts.sv
// Checker on the arbiter's ports, attached by bind.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module remote_arb_asserts
	import remote_arb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire remote_arb_pkg::remote_pins_t remote_pins_in,
	input wire logic core_data_memory_busy_in,
	input wire logic ad_oe_out,
	input wire remote_arb_pkg::strobes_t strobes_out,
	input wire logic transfer_ack_out,
	input wire logic bus_granted_remote_out,
	input wire logic core_data_memory_hold_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence req_s;
		$fell(remote_pins_in.select_n | (remote_pins_in.read_n & remote_pins_in.write_n));
	endsequence
	sequence grant_s;
		$rose(bus_granted_remote_out);
	endsequence
	sequence term_s;
		$rose(transfer_ack_out) && bus_granted_remote_out;
	endsequence
	// Pins pass a three-flop filter, so the answer lags by a few clocks
	AST_ACK_FALL: assert property (req_s |-> ##[1:8] !transfer_ack_out)
		else $error("acknowledge did not fall after a request");
	AST_NO_GRANT_BUSY: assert property (grant_s |-> !$past(core_data_memory_busy_in))
		else $error("grant given while core used data memory");
	AST_STROBE_LATE: assert property (grant_s |-> strobes_out.int_read_n && strobes_out.int_write_n)
		else $error("internal strobe low in the grant cycle");
	AST_ACCESS_MIN: assert property (grant_s |-> !transfer_ack_out [*2])
		else $error("access phase shorter than two states");
	AST_HOLD: assert property (grant_s |-> ##[0:1] core_data_memory_hold_out)
		else $error("core not held while bus granted");
	AST_STROBE_ACK: assert property ($rose(transfer_ack_out) |-> strobes_out.int_read_n && strobes_out.int_write_n)
		else $error("internal strobe still low at acknowledge rise");
	AST_GRANT_FALL: assert property (term_s |-> bus_granted_remote_out ##[1:40] !bus_granted_remote_out)
		else $error("grant did not end after acknowledge");
	AST_DATA_MEMORY_FLOAT: assert property (!(strobes_out.read_n && strobes_out.data_write_n) |-> !ad_oe_out)
		else $error("bus driven during data memory strobe");
endmodule
bind remote_host_access_arbiter remote_arb_asserts i_chk (.clk_in, .rst_in, .remote_pins_in,
	.core_data_memory_busy_in, .ad_oe_out, .strobes_out, .transfer_ack_out, .bus_granted_remote_out,
	.core_data_memory_hold_out);

// file: remote_arb_pkg.sv
// Constants and carriers for the remote host access arbiter.
// Assumes a single core-side clock; all T-state counts are core clock ticks.
package remote_arb_pkg;

	// APB register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] PC_OFFSET = 8'h08;

	// Control register fields
	localparam int CTRL_DIVIDE_BIT = 0;
	localparam int CTRL_LOCK_OUT_BIT = 1;
	localparam int CTRL_DATA_WAIT_LSB = 2;
	localparam int CTRL_INSTR_WAIT_LSB = 4;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// Status register fields
	localparam int STATUS_CONFIG_LSB = 0;
	localparam int STATUS_BYTE_HIGH_BIT = 8;
	localparam int STATUS_PHASE_LSB = 9;
	localparam int STATUS_GRANTED_BIT = 12;

	// Remote configuration register fields
	localparam int CFG_SELECT_LSB = 0;
	localparam int CFG_RUN_BIT = 2;
	localparam int CFG_LATCHED_WRITE_BIT = 3;
	localparam int CFG_LATCHED_READ_BIT = 4;
	localparam int CFG_FAST_WRITE_BIT = 5;
	localparam int CFG_STEP_BIT = 6;
	localparam int CFG_IRQ_STATUS_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h01;

	// Memory select codes
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_INSTR = 2'h1;
	localparam logic [1:0] SEL_PC_LOW = 2'h2;
	localparam logic [1:0] SEL_PC_HIGH = 2'h3;

	// Phase lengths in T-states and the program counter reset value
	localparam logic [2:0] ARB_MIN_T = 3'h1;
	localparam logic [2:0] ACCESS_MIN_T = 3'h2;
	localparam logic [2:0] TERM_MIN_T = 3'h1;
	localparam logic [15:0] PC_RESET = 16'h0000;

	typedef enum {PH_IDLE, PH_ARB, PH_ACCESS, PH_TERM, PH_RELEASE} phase_t;

	// Asynchronous pins from the remote processor side
	typedef struct packed {
		logic select_n;
		logic read_n;
		logic write_n;
		logic cmd;
		logic lock_n;
		logic wait_n;
	} remote_pins_t;

	// Strobes toward memories and the remote side
	typedef struct packed {
		logic int_read_n;
		logic int_write_n;
		logic read_n;
		logic data_write_n;
		logic instr_mem_write_strobe_n;
	} strobes_t;

	localparam remote_pins_t PINS_IDLE = 6'h3f;

endpackage

// file: remote_host_access_arbiter.sv
// Remote host access arbiter: arbitration, access and termination sequencing
// for an asynchronous remote processor, with an APB slave for core-side control.
// Assumes clk_in is the crystal clock and the core reports data memory use.
//
// Function
// - Core tick is crystal clock halved when divide bit is one, else undivided.
// - Access starts when select low with read or write low, no ordering.
// - Transfer acknowledge falls shortly after an access starts, usable as wait.
// - Grant only when core leaves data memory; lock-out-remote may delay longer.
// - Arbitration lasts at least one T-state, longer during core access or lock.
// - Command-select sampled once early in the access and held throughout.
// - Internal strobes fall one T-state after grant, rise with acknowledge.
// - Read strobe drives external read; write strobe loads PC, config, writes.
// - Access at least two T-states plus programmed waits, stretched by wait.
// - Acknowledge rise ends access; grant falls one T-state later, or at remote release when termination is buffered.
// - Command-select high reaches config register, even while core runs.
// - Config register sits on bus by default; write floats, captured at ack.
// - Config access phase exactly two T-states, only wait input stretches it.
// - Memory select: 00 data, 01 instruction, 10 PC low, 11 PC high.
// - Data memory access floats bus, strobes at least one T-state plus waits.
// - PC read byte driven one T-state after grant; writes float; two T-states.
// - Instruction memory low then high; holding register; PC steps after high.
// - Byte tracker resets low, toggles per instruction access, cleared by 01.
// - Instruction read byte driven after grant, up to three wait states.
// - Instruction write grant at least three T-states; PC steps after grant.
// - Config layout: select 1:0, run 2, latched write 3, latched read 4, etc.
// - While remote lock low and granted, core data memory accesses wait.
`timescale 1ns/1ps

module remote_host_access_arbiter
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire remote_arb_pkg::remote_pins_t remote_pins_in,
	input wire logic core_data_memory_busy_in,
	input wire logic core_step_done_in,
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic ad_oe_out,
	input wire logic [15:0] instr_in,
	output logic [15:0] instr_out,
	output remote_arb_pkg::strobes_t strobes_out,
	output logic transfer_ack_out,
	output logic bus_granted_remote_out,
	output logic core_tick_out,
	output logic core_data_memory_hold_out,
	output logic run_control_out,
	output logic single_step_out,
	output logic [15:0] pc_out
);
	import remote_arb_pkg::*;

	remote_pins_t sync1, sync2, sync3;
	remote_pins_t pins;
	logic [5:0] ctrl;
	logic divide_phase;
	logic tick;
	phase_t phase;
	logic [2:0] count;
	logic cmd_taken;
	logic cmd;
	logic is_write;
	logic [7:0] remote_config_reg;
	logic [7:0] instr_low_holding_reg;
	logic byte_high;
	logic [15:0] pc;
	logic pc_inc_pending;
	logic step_flag;
	logic [7:0] ad_q;
	logic [31:0] prdata;
	logic request, released;
	logic [1:0] target;
	logic [2:0] access_len;
	logic strobe_on, access_end, drive_read, buffered_term;
	logic apb_access;

	// Three stages; a change counts once the second and third stages agree
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sync1 <= PINS_IDLE;
			sync2 <= PINS_IDLE;
			sync3 <= PINS_IDLE;
			pins <= PINS_IDLE;
		end
		else if (ce_in)
		begin
			sync1 <= remote_pins_in;
			sync2 <= sync1;
			sync3 <= sync2;
			for (int i = 0; i < 6; i++)
			begin
				if (sync2[i] == sync3[i])
					pins[i] <= sync3[i];
			end
		end
	end

	assign request = !pins.select_n && (!pins.read_n || !pins.write_n);
	assign released = pins.select_n || (pins.read_n && pins.write_n);

	// Core tick from the crystal clock
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			divide_phase <= 1'b0;
		else if (ce_in)
			divide_phase <= ctrl[CTRL_DIVIDE_BIT] ? !divide_phase : 1'b0;
	end

	assign tick = ce_in && (!ctrl[CTRL_DIVIDE_BIT] || divide_phase);
	assign core_tick_out = tick;

	// Target and access length; config and PC ignore programmed waits
	assign target = cmd ? SEL_DATA : remote_config_reg[CFG_SELECT_LSB +: 2];
	always_comb
	begin
		access_len = ACCESS_MIN_T;
		if (!cmd && target == SEL_DATA)
			access_len = ACCESS_MIN_T + {1'b0, ctrl[CTRL_DATA_WAIT_LSB +: 2]};
		else if (!cmd && target == SEL_INSTR)
			access_len = ACCESS_MIN_T + {1'b0, ctrl[CTRL_INSTR_WAIT_LSB +: 2]};
	end

	assign strobe_on = (phase == PH_ACCESS) && (count >= ARB_MIN_T);
	// Compared without an increment: a count saturated by a long wait must not wrap
	assign access_end = tick && (phase == PH_ACCESS) && (count >= access_len - 3'h1)
		&& pins.wait_n;

	// Buffered read or slow buffered write holds the bus until the strobe drops
	assign buffered_term = is_write
		? !remote_config_reg[CFG_LATCHED_WRITE_BIT] && !remote_config_reg[CFG_FAST_WRITE_BIT]
		: !remote_config_reg[CFG_LATCHED_READ_BIT];

	// Arbitration and phase sequencing
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			phase <= PH_IDLE;
			count <= 3'h0;
			cmd_taken <= 1'b0;
			cmd <= 1'b0;
			is_write <= 1'b0;
		end
		else if (ce_in)
		begin
			case (phase)
				PH_IDLE:
				begin
					cmd_taken <= 1'b0;
					if (request)
					begin
						phase <= PH_ARB;
						is_write <= !pins.write_n;
					end
				end
				PH_ARB:
					if (tick)
					begin
						if (!cmd_taken)
						begin
							cmd <= pins.cmd;
							cmd_taken <= 1'b1;
						end
						else if (cmd || (!core_data_memory_busy_in && !ctrl[CTRL_LOCK_OUT_BIT]))
						begin
							phase <= PH_ACCESS;
							count <= 3'h0;
						end
					end
				PH_ACCESS:
					if (access_end)
					begin
						phase <= PH_TERM;
						count <= 3'h0;
					end
					else if (tick && count != 3'h7)
						count <= count + 3'h1;
				PH_TERM:
					if (tick && count + 3'h1 >= TERM_MIN_T && !(buffered_term && !released))
						phase <= PH_RELEASE;
				PH_RELEASE:
					if (released)
						phase <= PH_IDLE;
				default:
					phase <= PH_IDLE;
			endcase
		end
	end

	// Acknowledge low from request until the access phase ends
	assign transfer_ack_out = !(phase == PH_ARB || phase == PH_ACCESS);
	// The core runs on while the remote side is on a config access
	assign bus_granted_remote_out = !cmd && (phase == PH_ACCESS || phase == PH_TERM);
	assign core_data_memory_hold_out = bus_granted_remote_out
		|| (phase == PH_RELEASE && !pins.lock_n && !cmd);

	// Strobes
	always_comb
	begin
		strobes_out.int_read_n = !(strobe_on && !is_write);
		strobes_out.int_write_n = !(strobe_on && is_write);
		strobes_out.read_n = !(strobe_on && !is_write && !cmd && target == SEL_DATA);
		strobes_out.data_write_n = !(strobe_on && is_write && !cmd && target == SEL_DATA);
		strobes_out.instr_mem_write_strobe_n = !(strobe_on && is_write && !cmd
			&& target == SEL_INSTR && byte_high);
	end

	// Remote configuration register and single-step request
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			remote_config_reg <= CFG_RESET;
			step_flag <= 1'b0;
		end
		else if (ce_in)
		begin
			if (access_end && is_write && cmd)
			begin
				remote_config_reg <= ad_in;
				remote_config_reg[CFG_STEP_BIT] <= 1'b0;
			end
			// A new step request wins over the completion of the previous one
			if (access_end && is_write && cmd && ad_in[CFG_STEP_BIT])
				step_flag <= 1'b1;
			else if (core_step_done_in)
				step_flag <= 1'b0;
		end
	end

	assign run_control_out = remote_config_reg[CFG_RUN_BIT];
	assign single_step_out = step_flag;

	// Byte tracker, low-byte holding register and program counter
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			byte_high <= 1'b0;
			instr_low_holding_reg <= 8'h00;
			pc <= PC_RESET;
			pc_inc_pending <= 1'b0;
		end
		else if (ce_in)
		begin
			if (access_end && is_write && cmd && ad_in[CFG_SELECT_LSB +: 2] == SEL_INSTR)
				byte_high <= 1'b0;
			else if (access_end && !cmd && target == SEL_INSTR)
				byte_high <= !byte_high;
			if (access_end && is_write && !cmd && target == SEL_INSTR && !byte_high)
				instr_low_holding_reg <= ad_in;
			if (access_end && !cmd && target == SEL_INSTR && byte_high)
				pc_inc_pending <= 1'b1;
			if (access_end && is_write && !cmd && target == SEL_PC_LOW)
				pc[7:0] <= ad_in;
			else if (access_end && is_write && !cmd && target == SEL_PC_HIGH)
				pc[15:8] <= ad_in;
			else if (pc_inc_pending && tick && !bus_granted_remote_out)
			begin
				pc <= pc + 16'h0001;
				pc_inc_pending <= 1'b0;
			end
		end
	end

	assign pc_out = pc;

	// Loaded only during a high-byte write, so the word stands after the bus moves on
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			instr_out <= 16'h0000;
		else if (ce_in && phase == PH_ACCESS && is_write && !cmd && target == SEL_INSTR
			&& byte_high)
			instr_out <= {ad_in, instr_low_holding_reg};
	end

	// Bus output: config by default, selected byte on instruction and PC reads, floats on writes and data reads
	assign drive_read = !is_write && count >= ARB_MIN_T
		&& (target == SEL_INSTR || target == SEL_PC_LOW || target == SEL_PC_HIGH);
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			ad_q <= CFG_RESET;
		else if (ce_in)
		begin
			if (phase == PH_ACCESS && drive_read && target == SEL_INSTR)
				ad_q <= byte_high ? instr_in[15:8] : instr_in[7:0];
			else if (phase == PH_ACCESS && drive_read && target == SEL_PC_LOW)
				ad_q <= pc[7:0];
			else if (phase == PH_ACCESS && drive_read)
				ad_q <= pc[15:8];
			else if (phase != PH_TERM)
			begin
				ad_q <= remote_config_reg;
				ad_q[CFG_STEP_BIT] <= 1'b0;
			end
		end
	end

	assign ad_out = ad_q;
	// Writes float the bus, config writes too, so the remote byte is what gets captured
	assign ad_oe_out = !(bus_granted_remote_out
		|| (cmd && is_write && (phase == PH_ACCESS || phase == PH_TERM)))
		|| (!is_write && phase == PH_ACCESS && drive_read)
		|| (!is_write && phase == PH_TERM && target != SEL_DATA);

	// APB slave, zero wait states
	assign apb_access = psel_in && penable_in;
	assign pready_out = 1'b1;
	assign pslverr_out = apb_access && paddr_in != CTRL_OFFSET && paddr_in != STATUS_OFFSET
		&& paddr_in != PC_OFFSET;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			ctrl <= CTRL_RESET;
		else if (ce_in && apb_access && pwrite_in && paddr_in == CTRL_OFFSET)
			ctrl <= pwdata_in[5:0];
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		case (paddr_in)
			CTRL_OFFSET:
				prdata[5:0] = ctrl;
			STATUS_OFFSET:
			begin
				prdata[STATUS_CONFIG_LSB +: 8] = remote_config_reg;
				prdata[STATUS_BYTE_HIGH_BIT] = byte_high;
				prdata[STATUS_PHASE_LSB +: 3] = 3'(phase);
				prdata[STATUS_GRANTED_BIT] = bus_granted_remote_out;
			end
			PC_OFFSET:
				prdata[15:0] = pc;
			default:
				prdata = 32'h0000_0000;
		endcase
	end

	// Read data from a flop loaded during the setup cycle
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			prdata_out <= 32'h0000_0000;
		else if (ce_in && psel_in && !penable_in)
			prdata_out <= prdata;
	end

endmodule

// file: remote_host_model.sv
// Behavioural remote processor on the asynchronous access pins.
// Assumes the arbiter's bus output, enable and acknowledge come back to it.
`timescale 1ns/1ps
module remote_host_model
	import remote_arb_pkg::*;
(
	input wire logic clk_in,
	input wire logic ad_oe_in,
	input wire logic [7:0] ad_drv_in,
	input wire logic ack_in,
	output remote_arb_pkg::remote_pins_t pins_out,
	output logic [7:0] ad_out
);
	import remote_arb_pkg::*;
	logic drv = 1'b0;
	logic [7:0] dq = 8'h00;
	logic [7:0] pat = 8'h00;
	initial pins_out = PINS_IDLE;
	// A floating bus keeps changing, so stale data can never pass for a match
	always @(posedge clk_in) pat <= pat + 8'h3b;
	assign ad_out = ad_oe_in ? ad_drv_in : (drv ? dq : pat);
	task automatic access(input logic cmd, input logic wr, input logic [7:0] wd, input int wt,
		output logic [7:0] rd, output logic to);
		int n;
		pins_out <= {1'b0, wr, !wr, cmd, 1'b1, wt == 0};
		drv <= wr;
		dq <= wd;
		for (n = 0; n < 20 && ack_in; n++) @(posedge clk_in);
		to = ack_in;
		repeat (wt) @(posedge clk_in);
		pins_out.wait_n <= 1'b1;
		for (n = 0; n < 300 && !ack_in; n++) @(posedge clk_in);
		to = to | !ack_in;
		rd = ad_out;
		pins_out <= PINS_IDLE;
		drv <= 1'b0;
		repeat (10) @(posedge clk_in);
	endtask
endmodule

// file: tb.sv
// Self-checking bench: APB and remote accesses against the arbiter.
// Assumes the checker is bound and the host model sits on the remote pins.
`timescale 1ns/1ps
module tb;
	import remote_arb_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00, ad_in, ad_out, r;
	logic [31:0] pwdata_in = 32'h0, prdata_out, q;
	logic pready_out, pslverr_out, core_data_memory_busy_in = 1'b0, core_step_done_in = 1'b0, ad_oe_out;
	logic transfer_ack_out, bus_granted_remote_out, core_tick_out, core_data_memory_hold_out;
	logic run_control_out, single_step_out;
	logic [15:0] instr_in = 16'h0, instr_out, pc_out;
	remote_pins_t remote_pins_in;
	strobes_t strobes_out;
	int cyc = 0, ticks = 0, gr = 0, instr_mem_write_strobe = 0, rdn = 0, error_cnt = 0, check_count = 0, t, g, g0;
	remote_host_access_arbiter i_remote_host_access_arbiter (.clk_in, .rst_in, .ce_in(1'b1),
		.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .remote_pins_in, .core_data_memory_busy_in, .core_step_done_in, .ad_in, .ad_out,
		.ad_oe_out, .instr_in, .instr_out, .strobes_out, .transfer_ack_out,
		.bus_granted_remote_out, .core_tick_out, .core_data_memory_hold_out, .run_control_out,
		.single_step_out, .pc_out);
	remote_host_model host (.clk_in, .ad_oe_in(ad_oe_out), .ad_drv_in(ad_out),
		.ack_in(transfer_ack_out), .pins_out(remote_pins_in), .ad_out(ad_in));
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		core_data_memory_busy_in <= (cyc % 7) < 2;
		ticks <= ticks + core_tick_out;
		gr <= gr + bus_granted_remote_out;
		instr_mem_write_strobe <= instr_mem_write_strobe + !strobes_out.instr_mem_write_strobe_n;
		rdn <= rdn + !strobes_out.read_n;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task stop_on(input logic to);
		if (to)
		begin
			error_cnt++;
			end_sim;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (n = 0; n == 0 || (!pready_out && n < 20); n++) @(posedge clk_in);
		stop_on(!pready_out);
		q = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task rem(input logic cmd, input logic w, input logic [7:0] d, input int wt);
		logic to;
		host.access(cmd, w, d, wt, r, to);
		stop_on(to);
	endtask
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		apb(0, STATUS_OFFSET, 0); check(q, 32'h1);
		apb(0, PC_OFFSET, 0); check(q, 32'h0);
		apb(0, 8'h0c, 0); check(q, 32'h0);
		rem(1, 1, 8'h52, 0); check(single_step_out, 1'b1);
		rem(1, 0, 8'h00, 0); check(r, 8'h12);
		core_step_done_in <= 1'b1;
		@(posedge clk_in);
		core_step_done_in <= 1'b0;
		@(posedge clk_in); check(single_step_out, 1'b0);
		rem(0, 1, 8'h34, 0);
		rem(1, 1, 8'h13, 0);
		rem(0, 1, 8'ha5, 0); check(pc_out, 16'ha534);
		rem(0, 0, 8'h00, 0); check(r, 8'ha5);
		rem(1, 1, 8'h11, 0);
		rem(0, 1, 8'h66, 0);
		apb(0, STATUS_OFFSET, 0); check(q[8], 1'b1);
		rem(1, 1, 8'h11, 0);
		apb(0, STATUS_OFFSET, 0); check(q[8], 1'b0);
		t = instr_mem_write_strobe;
		rem(0, 1, 8'h77, 0); check(instr_mem_write_strobe, t);
		rem(0, 1, 8'h99, 0); check(instr_out, 16'h9977);
		check(instr_mem_write_strobe > t, 1'b1);
		check(pc_out, 16'ha535);
		instr_in <= 16'h5a3c;
		rem(0, 0, 8'h00, 0); check(r, 8'h3c);
		rem(0, 0, 8'h00, 0); check(r, 8'h5a);
		check(pc_out, 16'ha536);
		rem(1, 1, 8'h10, 0);
		t = rdn;
		g = gr;
		rem(0, 0, 8'h00, 0); check(rdn > t, 1'b1);
		g0 = gr - g;
		apb(1, CTRL_OFFSET, 32'hc);
		g = gr;
		rem(0, 0, 8'h00, 0); check(gr - g, g0 + 3);
		apb(1, CTRL_OFFSET, 32'h0);
		g = gr;
		rem(0, 0, 8'h00, 12); check(gr - g > g0 + 4, 1'b1);
		rem(0, 1, 8'h42, 0);
		apb(1, CTRL_OFFSET, 32'h2);
		g = gr;
		fork
			rem(0, 0, 8'h00, 0);
			begin
				repeat (30) @(posedge clk_in);
				check(gr, g);
				apb(1, CTRL_OFFSET, 32'h0);
			end
		join
		check(gr > g, 1'b1);
		apb(1, CTRL_OFFSET, 32'h1);
		t = ticks;
		repeat (20) @(posedge clk_in);
		check(ticks - t, 10);
		apb(1, CTRL_OFFSET, 32'h0);
		t = ticks;
		repeat (20) @(posedge clk_in);
		check(ticks - t, 20);
		rem(1, 1, 8'h14, 0); check(run_control_out, 1'b1);
		end_sim;
	end
endmodule
